//--- rcf_event_model.sv
// Event model for the reset detectors and stack logic beside the flag block.
// Assumes the bench raises fire for one pclk cycle per requested event.
`timescale 1ns/1ps
`default_nettype none
module rcf_event_model (
    input wire logic fire,
    input wire logic [2:0] sel,
    input wire logic pin_low,
    output logic bor_event,
    output logic wdt_reset_event,
    output logic wdt_wake_event,
    output logic wdt_clear_event,
    output logic sleep_event,
    output logic reset_instr_event,
    output logic stack_over_event,
    output logic stack_under_event,
    output logic external_reset_pin_n
);
    // One-hot decode, so only one detector pulses at a time
    assign bor_event = fire && (sel == 3'h0);
    assign wdt_reset_event = fire && (sel == 3'h1);
    assign wdt_wake_event = fire && (sel == 3'h2);
    assign wdt_clear_event = fire && (sel == 3'h3);
    assign sleep_event = fire && (sel == 3'h4);
    assign reset_instr_event = fire && (sel == 3'h5);
    assign stack_over_event = fire && (sel == 3'h6);
    assign stack_under_event = fire && (sel == 3'h7);
    // A level, never a glitch, so the synchroniser always sees it
    assign external_reset_pin_n = !pin_low;
endmodule : rcf_event_model
`default_nettype wire

//--- rcf_pkg.sv
// Constants for the reset cause flag block: register map, field positions
// and reset values.
// Assumes a 32-bit APB bus with byte addresses; only the low byte of data is used.
package rcf_pkg;
    // Bus geometry
    localparam int RCF_ADDR_W = 8;
    localparam int RCF_DATA_W = 32;
    localparam int RCF_FLAG_W = 8;

    // Register byte addresses
    localparam logic [RCF_ADDR_W-1:0] RCF_OFS_FLAGS = 8'h00;
    localparam logic [RCF_ADDR_W-1:0] RCF_OFS_CORE = 8'h04;

    // Field positions in reset_cause_flags
    localparam int RCF_BIT_STACK_OVER = 7;
    localparam int RCF_BIT_STACK_UNDER = 6;
    localparam int RCF_BIT_UNUSED = 5;
    localparam int RCF_BIT_WATCHDOG = 4;
    localparam int RCF_BIT_PIN = 3;
    localparam int RCF_BIT_SOFTWARE = 2;
    localparam int RCF_BIT_POWERON = 1;
    localparam int RCF_BIT_BROWNOUT = 0;

    // Field positions in the core status register
    localparam int RCF_BIT_TIMEOUT = 1;
    localparam int RCF_BIT_POWERDOWN = 0;

    // Values after power-on; brown-out reads zero, it is unknown in the part
    localparam logic [RCF_FLAG_W-1:0] RCF_FLAGS_POR = 8'h1c;
    // Implemented flag bits; bit 5 is missing
    localparam logic [RCF_FLAG_W-1:0] RCF_FLAGS_MASK = 8'hdf;
    // Timeout and power-down both read one after power-on
    localparam logic [1:0] RCF_CORE_POR = 2'h3;
endpackage : rcf_pkg

//--- rcf_reset_cause_flags.sv
// Reset cause flag register with the timeout and power-down status bits,
// reached as an APB slave.
// Assumes the reset detectors, stack logic and core pulse their events for
// one pclk cycle, and that presetn is the power-on reset itself.
//
// Summary of operation
// - One flag per reset source: stack overflow, stack underflow, watchdog, pin, reset instruction, power-on, brown-out.
// - Stack overflow (bit 7) and underflow (bit 6) are set by hardware on their error; firmware may clear them.
// - The watchdog flag (bit 4) is cleared by hardware on a watchdog timeout reset; one means none since set.
// - The pin flag (bit 3) is driven to zero while the external reset pin resets the device, else it holds unless a brown-out sets it.
// - The software reset flag (bit 2) is cleared by hardware when the reset instruction runs.
// - The power-on flag (bit 1) reads zero after power-on; firmware writes one to arm the next detection.
// - The brown-out flag (bit 0) reads zero after a brown-out; firmware sets it after power-on or brown-out.
// - Every implemented flag is readable and writable by firmware besides the hardware set and clear.
// - Bit 5 is not implemented: writes are ignored and it reads zero.
// - Every reset updates the flags by its cause; pin and reset instruction resets leave timeout and power-down, a watchdog reset clears timeout only.
// - Stack errors request a reset and set their flag only while the stack error reset enable is one.

`timescale 1ns/1ps
`default_nettype none

module rcf_reset_cause_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcf_pkg::RCF_ADDR_W-1:0] paddr,
    input wire logic [rcf_pkg::RCF_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [rcf_pkg::RCF_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bor_event,
    input wire logic wdt_reset_event,
    input wire logic wdt_wake_event,
    input wire logic wdt_clear_event,
    input wire logic sleep_event,
    input wire logic reset_instr_event,
    input wire logic stack_over_event,
    input wire logic stack_under_event,
    input wire logic stack_error_reset_enable,
    input wire logic external_reset_pin_n,
    output logic [rcf_pkg::RCF_FLAG_W-1:0] reset_cause_flags,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic stack_reset_req
);
    logic [rcf_pkg::RCF_FLAG_W-1:0] flags_q;
    logic [rcf_pkg::RCF_FLAG_W-1:0] flags_d;
    logic [1:0] core_q;
    logic [1:0] core_d;
    logic [rcf_pkg::RCF_DATA_W-1:0] rdata_q;
    logic err_q;
    logic stack_req_q;
    logic pin_meta_q;
    logic pin_sync_q;

    // Bus decode
    wire logic setup = psel && !penable;
    wire logic access = psel && penable;
    wire logic hit_flags = (paddr == rcf_pkg::RCF_OFS_FLAGS);
    wire logic hit_core = (paddr == rcf_pkg::RCF_OFS_CORE);
    wire logic bad_addr = !(hit_flags || hit_core);
    // Core status is read-only, a write to it is answered with an error
    wire logic bad_cycle = bad_addr || (pwrite && hit_core);
    wire logic wr_flags = access && pwrite && hit_flags && pstrb[0];
    wire logic [rcf_pkg::RCF_FLAG_W-1:0] wbyte = pwdata[rcf_pkg::RCF_FLAG_W-1:0];

    // Event qualification
    wire logic over_set = stack_over_event && stack_error_reset_enable;
    wire logic under_set = stack_under_event && stack_error_reset_enable;
    wire logic pin_reset = !pin_sync_q;

    // Stack flags: hardware set beats a firmware clear in the same cycle
    assign flags_d[rcf_pkg::RCF_BIT_STACK_OVER] = over_set ? 1'b1 :
        wr_flags ? wbyte[rcf_pkg::RCF_BIT_STACK_OVER] :
        bor_event ? 1'b0 : flags_q[rcf_pkg::RCF_BIT_STACK_OVER];
    assign flags_d[rcf_pkg::RCF_BIT_STACK_UNDER] = under_set ? 1'b1 :
        wr_flags ? wbyte[rcf_pkg::RCF_BIT_STACK_UNDER] :
        bor_event ? 1'b0 : flags_q[rcf_pkg::RCF_BIT_STACK_UNDER];
    assign flags_d[rcf_pkg::RCF_BIT_UNUSED] = 1'b0;

    // Active-low cause flags: the hardware clear beats a firmware write of one
    assign flags_d[rcf_pkg::RCF_BIT_WATCHDOG] = wdt_reset_event ? 1'b0 :
        wr_flags ? wbyte[rcf_pkg::RCF_BIT_WATCHDOG] :
        bor_event ? 1'b1 : flags_q[rcf_pkg::RCF_BIT_WATCHDOG];
    assign flags_d[rcf_pkg::RCF_BIT_PIN] = pin_reset ? 1'b0 :
        wr_flags ? wbyte[rcf_pkg::RCF_BIT_PIN] :
        bor_event ? 1'b1 : flags_q[rcf_pkg::RCF_BIT_PIN];
    assign flags_d[rcf_pkg::RCF_BIT_SOFTWARE] = reset_instr_event ? 1'b0 :
        wr_flags ? wbyte[rcf_pkg::RCF_BIT_SOFTWARE] :
        bor_event ? 1'b1 : flags_q[rcf_pkg::RCF_BIT_SOFTWARE];
    // Power-on flag is only zeroed by presetn or a firmware write; a brown-out leaves it alone
    assign flags_d[rcf_pkg::RCF_BIT_POWERON] = wr_flags ? wbyte[rcf_pkg::RCF_BIT_POWERON] :
        flags_q[rcf_pkg::RCF_BIT_POWERON];
    assign flags_d[rcf_pkg::RCF_BIT_BROWNOUT] = bor_event ? 1'b0 :
        wr_flags ? wbyte[rcf_pkg::RCF_BIT_BROWNOUT] : flags_q[rcf_pkg::RCF_BIT_BROWNOUT];

    // Timeout: watchdog events clear it, sleep and watchdog clear set it
    assign core_d[rcf_pkg::RCF_BIT_TIMEOUT] = (wdt_reset_event || wdt_wake_event) ? 1'b0 :
        (bor_event || sleep_event || wdt_clear_event) ? 1'b1 : core_q[rcf_pkg::RCF_BIT_TIMEOUT];
    // Power-down: sleep and a wake from sleep clear it
    assign core_d[rcf_pkg::RCF_BIT_POWERDOWN] = (sleep_event || wdt_wake_event) ? 1'b0 :
        (bor_event || wdt_clear_event) ? 1'b1 : core_q[rcf_pkg::RCF_BIT_POWERDOWN];

    // Read mux, captured in setup so the access phase needs no wait state
    wire logic [rcf_pkg::RCF_DATA_W-1:0] rd_mux = hit_flags ?
        {{(rcf_pkg::RCF_DATA_W-rcf_pkg::RCF_FLAG_W){1'b0}}, flags_q & rcf_pkg::RCF_FLAGS_MASK} :
        hit_core ? {{(rcf_pkg::RCF_DATA_W-2){1'b0}}, core_q} : '0;

    // Pin synchroniser, released level is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
        end else begin
            pin_meta_q <= external_reset_pin_n;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Flag and status storage; presetn stands for the power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= rcf_pkg::RCF_FLAGS_POR;
            core_q <= rcf_pkg::RCF_CORE_POR;
        end else begin
            flags_q <= flags_d;
            core_q <= core_d;
        end
    end

    // Bus answer registers and the stack reset request pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            err_q <= 1'b0;
            stack_req_q <= 1'b0;
        end else begin
            if (setup) begin
                rdata_q <= pwrite ? '0 : rd_mux;
                err_q <= bad_cycle;
            end
            stack_req_q <= over_set || under_set;
        end
    end

    // Outputs; pready is constant high, every access is zero wait
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = access && err_q;
    assign reset_cause_flags = flags_q;
    assign timeout_flag = core_q[rcf_pkg::RCF_BIT_TIMEOUT];
    assign powerdown_flag = core_q[rcf_pkg::RCF_BIT_POWERDOWN];
    assign stack_reset_req = stack_req_q;

    // Checks on the flag behaviour
    chk_over_set: assert property (@(posedge pclk) disable iff (!presetn)
        over_set |=> reset_cause_flags[rcf_pkg::RCF_BIT_STACK_OVER])
        else $error("stack overflow flag not set");

    chk_over_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(reset_cause_flags[rcf_pkg::RCF_BIT_STACK_OVER]) |->
        ($past(over_set) || ($past(wr_flags) && $past(pwdata[rcf_pkg::RCF_BIT_STACK_OVER]))))
        else $error("stack overflow flag rose without cause");

    chk_under_set: assert property (@(posedge pclk) disable iff (!presetn)
        under_set ##1 !under_set |-> reset_cause_flags[rcf_pkg::RCF_BIT_STACK_UNDER])
        else $error("stack underflow flag not set");

    chk_wdt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_reset_event |=> !reset_cause_flags[rcf_pkg::RCF_BIT_WATCHDOG] && !timeout_flag)
        else $error("watchdog reset did not clear its flag and timeout");

    chk_pin_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !external_reset_pin_n [*3] |=> !reset_cause_flags[rcf_pkg::RCF_BIT_PIN])
        else $error("pin reset flag not zero while pin held low");

    chk_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        reset_instr_event |=> !reset_cause_flags[rcf_pkg::RCF_BIT_SOFTWARE])
        else $error("reset instruction did not clear its flag");

    // A firmware write on the same edge outranks the brown-out clear of the stack bits
    chk_bor_update: assert property (@(posedge pclk) disable iff (!presetn)
        bor_event && !over_set && !under_set |=>
        (reset_cause_flags[rcf_pkg::RCF_BIT_BROWNOUT] == 1'b0) &&
        (reset_cause_flags[rcf_pkg::RCF_BIT_STACK_OVER:rcf_pkg::RCF_BIT_STACK_UNDER] ==
        $past(wr_flags ? pwdata[rcf_pkg::RCF_BIT_STACK_OVER:rcf_pkg::RCF_BIT_STACK_UNDER] : 2'b00)))
        else $error("brown-out update wrong");

    chk_fw_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_flags && !bor_event |=>
        reset_cause_flags[rcf_pkg::RCF_BIT_POWERON] == $past(pwdata[rcf_pkg::RCF_BIT_POWERON]))
        else $error("firmware write to power-on flag lost");

    chk_bit5_zero: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && hit_flags |-> prdata[rcf_pkg::RCF_BIT_UNUSED] == 1'b0)
        else $error("unimplemented bit read as one");

    chk_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_flags && !bor_event && !over_set && !under_set && !wdt_reset_event &&
        !reset_instr_event && pin_sync_q |=> $stable(reset_cause_flags))
        else $error("flags changed without own event or write");

    chk_stack_req: assert property (@(posedge pclk) disable iff (!presetn)
        stack_reset_req == $past(over_set || under_set))
        else $error("stack reset request does not follow enabled stack error");

    chk_sleep_pd: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_event && !wdt_reset_event && !wdt_wake_event |=> !powerdown_flag && timeout_flag)
        else $error("sleep did not update power-down and timeout");
endmodule : rcf_reset_cause_flags

`default_nettype wire

//--- tb.sv
// Self-checking bench: drives the flag block over APB and through the event model.
// Assumes rcf_pkg, the design and rcf_event_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] ofs_f = rcf_pkg::RCF_OFS_FLAGS;
    localparam logic [7:0] ofs_c = rcf_pkg::RCF_OFS_CORE;
    logic pclk, presetn, psel, penable, pwrite, fire, pin_low, stack_error_reset_enable;
    logic pready, pslverr, timeout_flag, powerdown_flag, stack_reset_req;
    logic bor_event, wdt_reset_event, wdt_wake_event, wdt_clear_event, sleep_event;
    logic reset_instr_event, stack_over_event, stack_under_event, external_reset_pin_n;
    logic [7:0] paddr, reset_cause_flags;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [2:0] sel;
    logic e;
    int mismatches, n_tests;
    rcf_event_model ev_u (
        .fire(fire),
        .sel(sel),
        .pin_low(pin_low),
        .bor_event(bor_event),
        .wdt_reset_event(wdt_reset_event),
        .wdt_wake_event(wdt_wake_event),
        .wdt_clear_event(wdt_clear_event),
        .sleep_event(sleep_event),
        .reset_instr_event(reset_instr_event),
        .stack_over_event(stack_over_event),
        .stack_under_event(stack_under_event),
        .external_reset_pin_n(external_reset_pin_n)
    );
    rcf_reset_cause_flags dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bor_event(bor_event),
        .wdt_reset_event(wdt_reset_event),
        .wdt_wake_event(wdt_wake_event),
        .wdt_clear_event(wdt_clear_event),
        .sleep_event(sleep_event),
        .reset_instr_event(reset_instr_event),
        .stack_over_event(stack_over_event),
        .stack_under_event(stack_under_event),
        .stack_error_reset_enable(stack_error_reset_enable),
        .external_reset_pin_n(external_reset_pin_n),
        .reset_cause_flags(reset_cause_flags),
        .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag),
        .stack_reset_req(stack_reset_req)
    );
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // Whole transfer; waits on pready instead of assuming zero wait states
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, x);
    endtask : rd
    // One event pulse; the stack request is looked at in its single cycle
    task automatic ev(input logic [2:0] s, input logic xr);
        @(posedge pclk);
        fire <= 1'b1;
        sel <= s;
        @(posedge pclk);
        fire <= 1'b0;
        #1 chk("stack_reset_req", {31'h0, stack_reset_req}, {31'h0, xr});
    endtask : ev
    task automatic t_bus();
        rd(ofs_f, 32'h1c, "flags_por");
        rd(ofs_c, 32'h3, "core_por");
        chk("good_err", {31'h0, e}, 32'h0);
        chk("pready", {31'h0, pready}, 32'h1);
        apb(1'b1, ofs_f, 32'hff);
        rd(ofs_f, 32'hdf, "flags_ones");
        pstrb <= 4'h0;
        apb(1'b1, ofs_f, 32'h0);
        pstrb <= 4'hf;
        rd(ofs_f, 32'hdf, "no_strobe");
        rd(8'h08, 32'h0, "unmapped");
        chk("unmapped_err", {31'h0, e}, 32'h1);
        // Core status is read-only: a write is refused and leaves it alone
        apb(1'b1, ofs_c, 32'h0);
        chk("core_wr_err", {31'h0, e}, 32'h1);
        rd(ofs_c, 32'h3, "core_wr_ignored");
        apb(1'b1, ofs_f, 32'h0);
        rd(ofs_f, 32'h0, "flags_zero");
        $display("test bus done");
    endtask : t_bus
    task automatic t_stack();
        ev(3'h6, 1'b0);
        rd(ofs_f, 32'h0, "stack_off");
        stack_error_reset_enable <= 1'b1;
        ev(3'h6, 1'b1);
        rd(ofs_f, 32'h80, "stack_over");
        ev(3'h7, 1'b1);
        rd(ofs_f, 32'hc0, "stack_under");
        apb(1'b1, ofs_f, 32'h1f);
        rd(ofs_f, 32'h1f, "stack_clear");
        // Hardware set and firmware clear land on one edge; the set must win
        fork
            apb(1'b1, ofs_f, 32'h1f);
            begin
                repeat (2) @(posedge pclk);
                fire <= 1'b1;
                sel <= 3'h6;
                @(posedge pclk);
                fire <= 1'b0;
            end
        join
        rd(ofs_f, 32'h9f, "set_beats_clear");
        apb(1'b1, ofs_f, 32'h1f);
        $display("test stack done");
    endtask : t_stack
    task automatic t_clear();
        ev(3'h1, 1'b0);
        rd(ofs_f, 32'h0f, "wdt_reset");
        rd(ofs_c, 32'h1, "core_wdt");
        ev(3'h5, 1'b0);
        rd(ofs_f, 32'h0b, "reset_instr");
        pin_low <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("pin_flag", {24'h0, reset_cause_flags}, 32'h03);
        pin_low <= 1'b0;
        ev(3'h2, 1'b0);
        rd(ofs_f, 32'h03, "wake_keeps");
        rd(ofs_c, 32'h0, "core_wake");
        ev(3'h3, 1'b0);
        rd(ofs_c, 32'h3, "core_clear");
        ev(3'h4, 1'b0);
        rd(ofs_c, 32'h2, "core_sleep");
        chk("core_pins", {30'h0, timeout_flag, powerdown_flag}, 32'h2);
        $display("test clear done");
    endtask : t_clear
    task automatic t_bor();
        ev(3'h6, 1'b1);
        ev(3'h0, 1'b0);
        rd(ofs_f, 32'h1e, "brownout");
        rd(ofs_c, 32'h3, "core_bor");
        apb(1'b1, ofs_f, 32'h1f);
        rd(ofs_f, 32'h1f, "bor_rearm");
        // Second power-on mid-run: the re-armed flags must show it again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ofs_f, 32'h1c, "por_again");
        rd(ofs_c, 32'h3, "core_por_again");
        $display("test bor done");
    endtask : t_bor
    // Watchdog: the whole run needs about 125 cycles
    initial begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, fire, pin_low, stack_error_reset_enable} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        sel = 3'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_bus();
        t_stack();
        t_clear();
        t_bor();
        stop_test();
    end
endmodule : tb
`default_nettype wire
